// *** eci_pkg.sv ***
// Package for the edge counter and interrupt block
package eci_pkg;
  localparam int ECI_NCH = 16;
  localparam int ECI_CW = 5;
  localparam int ECI_W = 32;
  localparam logic [31:0] ECI_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] ECI_CNT_M1 = 32'hffff_ffff;
  localparam int ECI_MAX_EDGE_HZ = 500;
  localparam int ECI_CLK_HZ = 100000000;
  localparam int ECI_MIN_EDGE_CYC = ECI_CLK_HZ / ECI_MAX_EDGE_HZ;

  typedef enum logic [1:0] {
    ECI_EDGE_IDLE,
    ECI_EDGE_RISE,
    ECI_EDGE_FALL
  } eci_edge_t;

  typedef enum logic [2:0] {
    ECI_CMD_NONE,
    ECI_CMD_EDGE,
    ECI_CMD_PRESET,
    ECI_CMD_ARM,
    ECI_CMD_DISARM,
    ECI_CMD_RESET
  } eci_op_t;

  typedef struct packed {
    eci_op_t op;
    logic [ECI_CW-1:0] ch;
    eci_edge_t edge_sel;
    logic [ECI_W-1:0] value;
  } eci_cmd_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ch;
    logic is_counter;
  } eci_irq_t;
endpackage : eci_pkg

// *** eci_cnt_mem.sv ***
// Counter storage for all channels with registered read port
`timescale 1ns/1ns
`default_nettype none
module eci_cnt_mem
  import eci_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ECI_NCH-1:0] we,
  input wire logic [ECI_NCH*ECI_W-1:0] wdata,
  input wire logic [3:0] rd_ch,
  output logic [ECI_NCH*ECI_W-1:0] cnt,
  output logic [ECI_W-1:0] rdata
);
  logic [ECI_NCH*ECI_W-1:0] mem_r, mem_nxt;
  logic [ECI_W-1:0] rdata_r, rdata_nxt;

  always_comb begin
    mem_nxt = mem_r;
    for (int i = 0; i < ECI_NCH; i++) begin
      if (we[i]) begin
        mem_nxt[i*ECI_W +: ECI_W] = wdata[i*ECI_W +: ECI_W];
      end
    end
    rdata_nxt = mem_r[rd_ch*ECI_W +: ECI_W];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_r <= '0;
      rdata_r <= ECI_CNT_RST;
    end else begin
      mem_r <= mem_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign cnt = mem_r;
  assign rdata = rdata_r;
endmodule : eci_cnt_mem
`default_nettype wire

// *** eci_top.sv ***
// Edge counter and interrupt logic for a sixteen-channel input card
// Overview of operation
// - Counter interrupt requested when an armed counter steps from -1 to 0.
// - Event arm and counter arm are held separately per channel.
// - Slot reset command disarms both interrupt types on every channel.
// - Lowest pending channel presented first; unserviced requests are retained.
// - Counter interrupt presented before event interrupt on the same channel.
// - Servicing clears the request and disarms that interrupt type.
// - Edge select is rising, falling or idle; idle after power-on.
// - Preset loads any signed 32-bit value; counter starts at zero.
// - Counter is a 32-bit two's complement up-counter wrapping naturally.
// - Disarming the counter interrupt leaves the event arm unchanged.
// - After rollover the counter keeps counting, next edge gives one.
// - While a request is unserviced, later edges add no further request.
// - Event interrupt fires once; needs re-arm before the next edge.
// - Counters accept edges up to 500 Hz without loss.
// - Armed channel requests an event interrupt on its selected edge.
`timescale 1ns/1ns
`default_nettype none
module eci_top
  import eci_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [ECI_NCH-1:0] CH_IN,
  input wire eci_cmd_t CMD,
  input wire logic SERVICE_ACK,
  input wire logic [3:0] READ_CH,
  output var eci_irq_t IRQ,
  output logic [ECI_W-1:0] READ_DATA,
  output logic [ECI_NCH-1:0] EVT_ARMED,
  output logic [ECI_NCH-1:0] CNT_ARMED
);
  logic [ECI_NCH-1:0] sync1_r, sync2_r, prev_r;
  logic [ECI_NCH-1:0] evt_arm_r, evt_arm_nxt;
  logic [ECI_NCH-1:0] cnt_arm_r, cnt_arm_nxt;
  logic [ECI_NCH-1:0] evt_pend_r, evt_pend_nxt;
  logic [ECI_NCH-1:0] cnt_pend_r, cnt_pend_nxt;
  eci_edge_t edge_r [ECI_NCH];
  eci_edge_t edge_nxt [ECI_NCH];
  eci_irq_t irq_r, irq_nxt;
  logic [ECI_NCH-1:0] hit, we;
  logic [ECI_NCH*ECI_W-1:0] cnt, wdata;
  logic [ECI_W-1:0] rdata;
  logic [ECI_NCH-1:0] svc_cnt, svc_evt, pre_hit;

  // Lowest channel with any pending request, counter before event
  function automatic eci_irq_t pick(input logic [ECI_NCH-1:0] cp,
                                    input logic [ECI_NCH-1:0] ep);
    eci_irq_t r;
    r = '0;
    for (int i = ECI_NCH - 1; i >= 0; i--) begin
      if (cp[i] || ep[i]) begin
        r.valid = 1'b1;
        r.ch = 4'(i);
        r.is_counter = cp[i];
      end
    end
    return r;
  endfunction : pick

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= CH_IN;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < ECI_NCH; g++) begin : g_edge
      // One count per transition, ample margin for slow edges
      assign hit[g] =
        (edge_r[g] == ECI_EDGE_RISE && sync2_r[g] && !prev_r[g])
        || (edge_r[g] == ECI_EDGE_FALL && !sync2_r[g] && prev_r[g]);
    end
  endgenerate

  always_comb begin
    logic [ECI_W-1:0] c;
    logic sel;
    c = '0;
    sel = 1'b0;
    evt_arm_nxt = evt_arm_r;
    cnt_arm_nxt = cnt_arm_r;
    evt_pend_nxt = evt_pend_r;
    cnt_pend_nxt = cnt_pend_r;
    we = '0;
    wdata = cnt;
    for (int i = 0; i < ECI_NCH; i++) begin
      edge_nxt[i] = edge_r[i];
    end
    // Service first; an edge on the serviced channel that cycle adds no request of the serviced type, whose pending bit is still set
    if (SERVICE_ACK && irq_r.valid) begin
      if (irq_r.is_counter) begin
        cnt_pend_nxt[irq_r.ch] = 1'b0;
        cnt_arm_nxt[irq_r.ch] = 1'b0;
      end else begin
        evt_pend_nxt[irq_r.ch] = 1'b0;
        evt_arm_nxt[irq_r.ch] = 1'b0;
      end
    end
    for (int i = 0; i < ECI_NCH; i++) begin
      c = cnt[i*ECI_W +: ECI_W];
      if (hit[i]) begin
        we[i] = 1'b1;
        wdata[i*ECI_W +: ECI_W] = c + 32'h1;
        // Arm stays until service, so pending blocks repeat requests
        if (cnt_arm_r[i] && !cnt_pend_r[i] && c == ECI_CNT_M1) begin
          cnt_pend_nxt[i] = 1'b1;
        end
        if (evt_arm_r[i] && !evt_pend_r[i]) begin
          evt_pend_nxt[i] = 1'b1;
        end
      end
    end
    unique case (CMD.op)
      ECI_CMD_NONE: begin
      end
      ECI_CMD_EDGE: begin
        edge_nxt[CMD.ch[3:0]] = CMD.edge_sel;
      end
      ECI_CMD_PRESET: begin
        we[CMD.ch[3:0]] = 1'b1;
        wdata[CMD.ch[3:0]*ECI_W +: ECI_W] = CMD.value;
      end
      ECI_CMD_ARM, ECI_CMD_DISARM: begin
        sel = (CMD.op == ECI_CMD_ARM);
        if (CMD.ch[4]) begin
          evt_arm_nxt[CMD.ch[3:0]] = sel;
        end else begin
          cnt_arm_nxt[CMD.ch[3:0]] = sel;
        end
      end
      ECI_CMD_RESET: begin
        evt_arm_nxt = '0;
        cnt_arm_nxt = '0;
      end
      default: begin
      end
    endcase
    irq_nxt = pick(cnt_pend_nxt, evt_pend_nxt);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      evt_arm_r <= '0;
      cnt_arm_r <= '0;
      evt_pend_r <= '0;
      cnt_pend_r <= '0;
      irq_r <= '0;
      for (int i = 0; i < ECI_NCH; i++) begin
        edge_r[i] <= ECI_EDGE_IDLE;
      end
    end else begin
      evt_arm_r <= evt_arm_nxt;
      cnt_arm_r <= cnt_arm_nxt;
      evt_pend_r <= evt_pend_nxt;
      cnt_pend_r <= cnt_pend_nxt;
      irq_r <= irq_nxt;
      for (int i = 0; i < ECI_NCH; i++) begin
        edge_r[i] <= edge_nxt[i];
      end
    end
  end

  eci_cnt_mem u_mem (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .we(we),
    .wdata(wdata),
    .rd_ch(READ_CH),
    .cnt(cnt),
    .rdata(rdata)
  );

  assign IRQ = irq_r;
  assign READ_DATA = rdata;
  assign EVT_ARMED = evt_arm_r;
  assign CNT_ARMED = cnt_arm_r;

  reset_disarm_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    CMD.op == ECI_CMD_RESET |=> evt_arm_r == '0 && cnt_arm_r == '0)
    else $error("reset command left a channel armed");
  low_first_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    irq_r.valid |-> ((cnt_pend_r | evt_pend_r) &
      ((16'h1 << irq_r.ch) - 16'h1)) == '0)
    else $error("lower channel pending but not presented");
  cnt_before_evt_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    irq_r.valid && cnt_pend_r[irq_r.ch] |-> irq_r.is_counter)
    else $error("event presented before counter");
  service_clear_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    SERVICE_ACK && irq_r.valid && irq_r.is_counter && CMD.op == ECI_CMD_NONE
    |=> !cnt_pend_r[$past(irq_r.ch)] && !cnt_arm_r[$past(irq_r.ch)])
    else $error("serviced counter request not cleared");
  disarm_keep_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    CMD.op == ECI_CMD_DISARM && !CMD.ch[4] && !SERVICE_ACK
    |=> evt_arm_r == $past(evt_arm_r))
    else $error("counter disarm touched event arm");
  arm_keep_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    CMD.op == ECI_CMD_ARM && CMD.ch[4] && !SERVICE_ACK
    |=> cnt_arm_r == $past(cnt_arm_r))
    else $error("event arm touched counter arm");
  read_back_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    1'b1 |=> rdata == $past(cnt[READ_CH*ECI_W +: ECI_W]))
    else $error("read data is not the addressed count");

  // Per-channel decodes and checks
  generate
    for (g = 0; g < ECI_NCH; g++) begin : g_chk
      assign svc_cnt[g] = SERVICE_ACK && irq_r.valid && irq_r.is_counter
        && irq_r.ch == 4'(g);
      assign svc_evt[g] = SERVICE_ACK && irq_r.valid && !irq_r.is_counter
        && irq_r.ch == 4'(g);
      assign pre_hit[g] = CMD.op == ECI_CMD_PRESET && CMD.ch[3:0] == 4'(g);

      rollover_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        hit[g] && cnt_arm_r[g] && !cnt_pend_r[g] && !pre_hit[g]
        && cnt[g*ECI_W +: ECI_W] == ECI_CNT_M1
        |=> cnt_pend_r[g] && cnt[g*ECI_W +: ECI_W] == ECI_CNT_RST)
        else $error("rollover did not raise counter request");
      count_step_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        hit[g] && !pre_hit[g]
        |=> cnt[g*ECI_W +: ECI_W] == $past(cnt[g*ECI_W +: ECI_W]) + 32'h1)
        else $error("counter did not step by one");
      preset_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        pre_hit[g] |=> cnt[g*ECI_W +: ECI_W] == $past(CMD.value))
        else $error("preset not loaded");
      edge_once_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        hit[g] |=> !hit[g])
        else $error("one transition counted twice");
      idle_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        edge_r[g] == ECI_EDGE_IDLE |-> !hit[g])
        else $error("idle channel counted");
      edge_cfg_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        CMD.op == ECI_CMD_EDGE && CMD.ch[3:0] == 4'(g)
        |=> edge_r[g] == $past(CMD.edge_sel))
        else $error("edge select not taken");
      cnt_hold_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        !hit[g] && !pre_hit[g]
        |=> cnt[g*ECI_W +: ECI_W] == $past(cnt[g*ECI_W +: ECI_W]))
        else $error("count moved without an edge or preset");
      event_raise_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        hit[g] && evt_arm_r[g] && !evt_pend_r[g] |=> evt_pend_r[g])
        else $error("armed edge raised no event request");
      event_block_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        !evt_arm_r[g] && !evt_pend_r[g] |=> !evt_pend_r[g])
        else $error("disarmed channel raised an event request");
      cnt_retain_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        cnt_pend_r[g] && !svc_cnt[g] |=> cnt_pend_r[g])
        else $error("unserviced counter request lost");
      evt_retain_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        evt_pend_r[g] && !svc_evt[g] |=> evt_pend_r[g])
        else $error("unserviced event request lost");
      cnt_no_repeat_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        svc_cnt[g] && CMD.op != ECI_CMD_ARM |=> !cnt_pend_r[g])
        else $error("counter request repeated after service");
      evt_no_repeat_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        svc_evt[g] && CMD.op != ECI_CMD_ARM |=> !evt_pend_r[g])
        else $error("event request repeated after service");
      cnt_arm_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        (CMD.op == ECI_CMD_ARM || CMD.op == ECI_CMD_DISARM)
        && CMD.ch == 5'(g)
        |=> cnt_arm_r[g] == ($past(CMD.op) == ECI_CMD_ARM))
        else $error("counter arm command not applied");
      evt_arm_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        (CMD.op == ECI_CMD_ARM || CMD.op == ECI_CMD_DISARM)
        && CMD.ch == 5'(g + ECI_NCH)
        |=> evt_arm_r[g] == ($past(CMD.op) == ECI_CMD_ARM))
        else $error("event arm command not applied");
    end
  endgenerate

  cov_cnt_c: cover property (@(posedge SYS_CLK) irq_r.valid && irq_r.is_counter);
  cov_cnt_evt_c: cover property (@(posedge SYS_CLK)
    svc_cnt != '0 && (svc_cnt & evt_pend_r) != '0);
  cov_evt_c: cover property (@(posedge SYS_CLK) irq_r.valid && !irq_r.is_counter);
  cov_both_c: cover property (@(posedge SYS_CLK) (cnt_pend_r & evt_pend_r) != '0);
  cov_ack_c: cover property (@(posedge SYS_CLK) SERVICE_ACK && irq_r.valid);
endmodule : eci_top
`default_nettype wire

// *** eci_host.sv ***
// Mainframe model that services each presented interrupt request while go is high
`timescale 1ns/1ns
`default_nettype none
module eci_host
  import eci_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire eci_irq_t irq,
  output logic ack,
  output var eci_irq_t last
);
  initial ack = 1'b0;
  initial last = '0;
  // One-cycle service pulse, then a gap so the next request can settle
  always @(posedge clk) begin
    if (go && irq.valid === 1'b1 && !ack) begin
      ack <= 1'b1;
      last <= irq;
    end else begin
      ack <= 1'b0;
    end
  end
endmodule : eci_host
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the edge counter and interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import eci_pkg::*;
  logic clk, rst_n, go, ack;
  logic [15:0] ch_in, evt_a, cnt_a;
  logic [3:0] rd_ch;
  logic [31:0] rdata;
  eci_cmd_t cmd;
  eci_irq_t irq, last;
  int num_errors = 0;
  int n_checks = 0;
  eci_top i_dut (.SYS_CLK(clk), .RESETN(rst_n), .CH_IN(ch_in), .CMD(cmd),
    .SERVICE_ACK(ack), .READ_CH(rd_ch), .IRQ(irq), .READ_DATA(rdata),
    .EVT_ARMED(evt_a), .CNT_ARMED(cnt_a));
  eci_host i_host (.clk(clk), .go(go), .irq(irq), .ack(ack), .last(last));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input eci_op_t op, input logic [4:0] c,
                     input eci_edge_t e, input logic [31:0] v);
    @(negedge clk);
    cmd = '{op, c, e, v};
    @(negedge clk);
    cmd = '{ECI_CMD_NONE, 5'h00, ECI_EDGE_IDLE, 32'h0};
  endtask : run
  // Toggle one input and let it pass sync, compare and count stages
  task automatic tgl(input int c);
    @(negedge clk);
    ch_in[c] = ~ch_in[c];
    repeat (6) @(negedge clk);
  endtask : tgl
  task automatic rd(input logic [3:0] c, input logic [31:0] exp);
    @(negedge clk);
    rd_ch = c;
    repeat (2) @(negedge clk);
    chk(rdata, exp);
  endtask : rd
  task automatic svc(input logic [3:0] c, input logic is_cnt);
    int i;
    for (i = 0; i < 50 && ack !== 1'b1; i++) @(negedge clk);
    chk({26'h0, last}, {26'h0, 1'b1, c, is_cnt});
    @(negedge clk);
  endtask : svc
  task automatic t_reset;
    chk({evt_a, cnt_a}, 32'h0);
    chk({26'h0, irq}, 32'h0);
    rd(4'h0, 32'h0);
    tgl(7);
    tgl(7);
    rd(4'h7, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_count;
    run(ECI_CMD_EDGE, 5'h02, ECI_EDGE_RISE, 32'h0);
    run(ECI_CMD_PRESET, 5'h02, ECI_EDGE_IDLE, 32'hffff_ffff);
    run(ECI_CMD_ARM, 5'h02, ECI_EDGE_IDLE, 32'h0);
    chk({16'h0, cnt_a}, 32'h0000_0004);
    rd(4'h2, 32'hffff_ffff);
    tgl(2);
    go = 1'b1;
    svc(4'h2, 1'b1);
    go = 1'b0;
    chk({16'h0, cnt_a}, 32'h0);
    rd(4'h2, 32'h0);
    tgl(2);
    tgl(2);
    rd(4'h2, 32'h0000_0001);
    $display("t_count done");
  endtask : t_count
  task automatic t_prio;
    run(ECI_CMD_EDGE, 5'h03, ECI_EDGE_RISE, 32'h0);
    run(ECI_CMD_EDGE, 5'h05, ECI_EDGE_FALL, 32'h0);
    run(ECI_CMD_PRESET, 5'h03, ECI_EDGE_IDLE, 32'hffff_ffff);
    run(ECI_CMD_ARM, 5'h03, ECI_EDGE_IDLE, 32'h0);
    run(ECI_CMD_ARM, 5'h13, ECI_EDGE_IDLE, 32'h0);
    run(ECI_CMD_ARM, 5'h15, ECI_EDGE_IDLE, 32'h0);
    tgl(5);
    chk({26'h0, irq}, 32'h0);
    @(negedge clk);
    ch_in[3] = 1'b1;
    ch_in[5] = 1'b0;
    repeat (6) @(negedge clk);
    tgl(5);
    tgl(5);
    go = 1'b1;
    svc(4'h3, 1'b1);
    svc(4'h3, 1'b0);
    svc(4'h5, 1'b0);
    repeat (10) @(negedge clk);
    chk({31'h0, irq.valid}, 32'h0);
    chk({evt_a, cnt_a}, 32'h0);
    tgl(5);
    tgl(5);
    chk({31'h0, irq.valid}, 32'h0);
    rd(4'h5, 32'h0000_0003);
    go = 1'b0;
    $display("t_prio done");
  endtask : t_prio
  task automatic t_burst;
    int k;
    run(ECI_CMD_EDGE, 5'h06, ECI_EDGE_FALL, 32'h0);
    for (k = 0; k < 8; k++) begin
      @(negedge clk);
      ch_in[6] = ~ch_in[6];
      repeat (3) @(negedge clk);
    end
    rd(4'h6, 32'h0000_0004);
    run(ECI_CMD_EDGE, 5'h06, ECI_EDGE_IDLE, 32'h0);
    tgl(6);
    tgl(6);
    rd(4'h6, 32'h0000_0004);
    $display("t_burst done");
  endtask : t_burst
  task automatic t_disarm;
    run(ECI_CMD_ARM, 5'h04, ECI_EDGE_IDLE, 32'h0);
    run(ECI_CMD_ARM, 5'h14, ECI_EDGE_IDLE, 32'h0);
    run(ECI_CMD_DISARM, 5'h04, ECI_EDGE_IDLE, 32'h0);
    chk({evt_a, cnt_a}, 32'h0010_0000);
    run(ECI_CMD_ARM, 5'h09, ECI_EDGE_IDLE, 32'h0);
    run(ECI_CMD_RESET, 5'h00, ECI_EDGE_IDLE, 32'h0);
    chk({evt_a, cnt_a}, 32'h0);
    $display("t_disarm done");
  endtask : t_disarm
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    ch_in = 16'h0000;
    rd_ch = 4'h0;
    cmd = '{ECI_CMD_NONE, 5'h00, ECI_EDGE_IDLE, 32'h0};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_count();
    t_prio();
    t_disarm();
    t_burst();
    finish_test();
  end
endmodule : tb
`default_nettype wire
